// File: rtl/ipr_top.sv
`timescale 1ns/1ps
module ipr_top
    import ipr_pkg::*;
#(
    parameter int unsigned SRC_N = NUM_SRC
)
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [SRC_N-1:0] req_raw_i,
    output logic [SRC_N-1:0] req_o,
    output logic [PRIO_W*SRC_N-1:0] prio_o
);

    // Reset release synchroniser
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Bus slave state, one packed record
    typedef struct packed {
        ipr_phase_e phase; // Where the current transfer stands
        logic mapped; // Data phase targets a real register
        logic [2:0] idx; // Register index of the data phase
        logic hready; // Drives hreadyout
        logic hresp; // Always OKAY
        logic [31:0] hrdata; // Read data held for the master
    } ipr_bus_s;

    ipr_bus_s st_reg;
    ipr_bus_s st_next;

    // Address phase decode results
    logic addr_take;
    logic addr_mapped;
    logic [2:0] addr_idx;

    // Field values and the read view built from them
    logic [2:0] prio_w [SRC_N];
    logic [15:0] rb_word [NUM_REG];

    // Field links
    ipr_fld_if fld_if [SRC_N] ();

    // Release reset two edges after the pin rises; assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // A transfer is taken only when the bus is ready and we are selected
    assign addr_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

    // Match the window offset against the map; anything else is unmapped
    // Upper address bits are ignored, so the map repeats every 256 bytes
    always_comb begin
        addr_mapped = 1'b0;
        addr_idx = 3'h0;
        for (int r = 0; r < NUM_REG; r++) begin
            if (haddr_i[ADDR_W-1:0] == REG_OFF[r]) begin
                addr_mapped = 1'b1;
                addr_idx = 3'(r);
            end
        end
    end

    // One field instance per source; write slices only implemented bits
    for (genvar s = 0; s < SRC_N; s++) begin : g_fld
        // Commit in the write data phase of the owning register
        assign fld_if[s].wr_en = (st_reg.phase == PH_WRITE) && st_reg.mapped
            && (st_reg.idx == FLD_REG[s]);
        // Bits outside the field never reach storage
        assign fld_if[s].wdata = hwdata_i[FLD_LSB[s] +: PRIO_W];
        assign fld_if[s].req_raw = req_raw_i[s];
        assign prio_w[s] = fld_if[s].prio;
        assign req_o[s] = fld_if[s].req_out;
        assign prio_o[s*PRIO_W +: PRIO_W] = fld_if[s].prio;

        ipr_field u_field (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n),
            .fld(fld_if[s])
        );
    end

    // Assemble each register from its fields; unplaced bits stay zero
    always_comb begin
        for (int r = 0; r < NUM_REG; r++) begin
            rb_word[r] = 16'h0000;
        end
        // Field table places each source at its fixed position in its register
        for (int s = 0; s < SRC_N; s++) begin
            rb_word[FLD_REG[s]][FLD_LSB[s] +: PRIO_W] =
                prio_w[s];
        end
    end

    // Slave phase sequencing
    // Reads take one wait state so that a write just committed is seen;
    // writes finish with no wait state.
    always_comb begin
        st_next = st_reg;
        st_next.hresp = HRESP_OKAY;
        st_next.hready = 1'b1;
        unique case (st_reg.phase)
            PH_READ_WAIT: begin
                // Sample the register now that any prior write has landed
                st_next.phase = PH_READ_DATA;
                if (st_reg.mapped) begin
                    st_next.hrdata = {16'h0000, rb_word[st_reg.idx]};
                end else begin
                    // Unmapped reads answer zero, still OKAY
                    st_next.hrdata = 32'h0000_0000;
                end
            end
            PH_IDLE, PH_WRITE, PH_READ_DATA: begin
                if (addr_take) begin
                    st_next.mapped = addr_mapped;
                    st_next.idx = addr_idx;
                    if (hwrite_i) begin
                        st_next.phase = PH_WRITE;
                    end else begin
                        // Stall the data phase by one cycle
                        st_next.phase = PH_READ_WAIT;
                        st_next.hready = 1'b0;
                    end
                end else begin
                    st_next.phase = PH_IDLE;
                end
            end
        endcase
    end

    // Slave state register
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.phase <= PH_IDLE;
            st_reg.mapped <= 1'b0;
            st_reg.idx <= 3'h0;
            st_reg.hready <= 1'b1;
            st_reg.hresp <= HRESP_OKAY;
            st_reg.hrdata <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus outputs straight from the state register
    assign hrdata_o = st_reg.hrdata;
    assign hreadyout_o = st_reg.hready;
    assign hresp_o = st_reg.hresp;

    // Transfer size is not checked; every access is treated as a word
    // A byte write therefore loads every field of the addressed word
    logic size_unused;
    assign size_unused = ^hsize_i;

    // Read completion marker for the checks below
    logic rd_done;
    assign rd_done = (st_reg.phase == PH_READ_DATA) && st_reg.mapped;

    // Read is accepted, then stalls exactly one cycle
    sequence seq_rd_accept;
        hsel_i && hready_i && (htrans_i == 2'h2) && !hwrite_i;
    endsequence

    sequence seq_rd_stall;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    chk_read_wait: assert property (@(posedge mclk_i) disable iff (!rst_n)
        seq_rd_accept |=> seq_rd_stall)
        else $error("read did not take exactly one wait state");

    // Write data phase never stalls
    chk_write_ready: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (hsel_i && hready_i && (htrans_i == 2'h2) && hwrite_i) |=> hreadyout_o)
        else $error("write data phase stalled");

    // First enabled edge after reset: bus idle and every field at level four
    chk_reset_outputs: assert property (@(posedge mclk_i) $rose(rst_n) |->
        (hreadyout_o && !hresp_o && (hrdata_o == 32'h0000_0000) && (req_o == '0)
        && (prio_o == {SRC_N{PRIO_RESET}})))
        else $error("outputs not at reset state after reset release");

    // Unimplemented positions read back as zero after any write
    chk_unimpl_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
        rd_done |-> ((st_reg.hrdata[31:16] == 16'h0000)
        && ((st_reg.hrdata[15:0] & ~REG_MASK[st_reg.idx]) == 16'h0000)))
        else $error("unimplemented bits read nonzero");

    // All-ones write to the second register sets both of its fields to seven
    chk_write_mask: assert property (@(posedge mclk_i) disable iff (!rst_n)
        ((st_reg.phase == PH_WRITE) && st_reg.mapped && (hwdata_i[15:0] == 16'hffff)
        && (st_reg.idx == 3'h1)) |=> (prio_w[4] == 3'h7) && (prio_w[5] == 3'h7))
        else $error("all-ones write did not set second register fields");

    // First register layout
    chk_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (rd_done && (st_reg.idx == 3'h0)) |-> ((st_reg.hrdata[14:12] == prio_w[0])
        && (st_reg.hrdata[10:8] == prio_w[1]) && (st_reg.hrdata[6:4] == prio_w[2])
        && (st_reg.hrdata[2:0] == prio_w[3])))
        else $error("first register fields misplaced");

    // Second register layout
    chk_read_b: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (rd_done && (st_reg.idx == 3'h1)) |-> ((st_reg.hrdata[6:4] == prio_w[4])
        && (st_reg.hrdata[2:0] == prio_w[5]) && (st_reg.hrdata[15:7] == 9'h000)))
        else $error("second register fields misplaced");

    // Third register layout
    chk_read_c: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (rd_done && (st_reg.idx == 3'h2)) |-> ((st_reg.hrdata[14:12] == prio_w[6])
        && (st_reg.hrdata[10:8] == prio_w[7]) && (st_reg.hrdata[6:4] == prio_w[8])
        && (st_reg.hrdata[2:0] == prio_w[9])))
        else $error("third register fields misplaced");

    // Fourth register layout
    chk_read_d: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (rd_done && (st_reg.idx == 3'h3)) |-> ((st_reg.hrdata[2:0] == prio_w[10])
        && (st_reg.hrdata[15:3] == 13'h0000)))
        else $error("fourth register fields misplaced");

    // Fifth register layout
    chk_read_e: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (rd_done && (st_reg.idx == 3'h4)) |-> ((st_reg.hrdata[14:12] == prio_w[11])
        && (st_reg.hrdata[10:8] == prio_w[12]) && (st_reg.hrdata[6:4] == prio_w[13])
        && (st_reg.hrdata[3:0] == 4'h0)))
        else $error("fifth register fields misplaced");

    // Write side: a committed data phase lands in the fixed bit positions
    // Positions are spelled out here, so a wrong field table shows up on writes too
    logic wr_phase;
    assign wr_phase = (st_reg.phase == PH_WRITE) && st_reg.mapped;

    // First register write
    chk_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_phase && (st_reg.idx == 3'h0)) |=> ((prio_w[0] == $past(hwdata_i[14:12]))
        && (prio_w[1] == $past(hwdata_i[10:8])) && (prio_w[2] == $past(hwdata_i[6:4]))
        && (prio_w[3] == $past(hwdata_i[2:0]))))
        else $error("first register write misplaced");

    // Second register write
    chk_write_b: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_phase && (st_reg.idx == 3'h1)) |=> ((prio_w[4] == $past(hwdata_i[6:4]))
        && (prio_w[5] == $past(hwdata_i[2:0]))))
        else $error("second register write misplaced");

    // Third register write
    chk_write_c: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_phase && (st_reg.idx == 3'h2)) |=> ((prio_w[6] == $past(hwdata_i[14:12]))
        && (prio_w[7] == $past(hwdata_i[10:8])) && (prio_w[8] == $past(hwdata_i[6:4]))
        && (prio_w[9] == $past(hwdata_i[2:0]))))
        else $error("third register write misplaced");

    // Fourth register write
    chk_write_d: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_phase && (st_reg.idx == 3'h3)) |=> (prio_w[10] == $past(hwdata_i[2:0])))
        else $error("fourth register write misplaced");

    // Fifth register write
    chk_write_e: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_phase && (st_reg.idx == 3'h4)) |=> ((prio_w[11] == $past(hwdata_i[14:12]))
        && (prio_w[12] == $past(hwdata_i[10:8])) && (prio_w[13] == $past(hwdata_i[6:4]))))
        else $error("fifth register write misplaced");

    // A write to an unmapped offset changes no field
    chk_unmapped_write: assert property (@(posedge mclk_i) disable iff (!rst_n)
        ((st_reg.phase == PH_WRITE) && !st_reg.mapped) |=> $stable(prio_o))
        else $error("unmapped write changed a priority field");

    // An unmapped read answers zero
    chk_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rst_n)
        ((st_reg.phase == PH_READ_DATA) && !st_reg.mapped) |-> (hrdata_o == 32'h0000_0000))
        else $error("unmapped read returned nonzero data");

endmodule // ipr_top

// File: rtl/ipr_pkg.sv
// Shared constants for the interrupt priority register block
package ipr_pkg;

    // Register map, byte addresses inside the slave window
    localparam int unsigned NUM_REG = 5;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] PRIO_CFG_A_OFF = 8'h00;
    localparam logic [7:0] PRIO_CFG_B_OFF = 8'h04;
    localparam logic [7:0] PRIO_CFG_C_OFF = 8'h08;
    localparam logic [7:0] PRIO_CFG_D_OFF = 8'h0c;
    localparam logic [7:0] PRIO_CFG_E_OFF = 8'h10;
    localparam logic [7:0] REG_OFF [NUM_REG] = '{PRIO_CFG_A_OFF, PRIO_CFG_B_OFF,
        PRIO_CFG_C_OFF, PRIO_CFG_D_OFF, PRIO_CFG_E_OFF};

    // Implemented bits of each 16-bit register; the rest read zero
    localparam logic [15:0] REG_MASK [NUM_REG] = '{16'h7777, 16'h0077, 16'h7777,
        16'h0007, 16'h7770};

    // Priority field coding
    localparam int unsigned PRIO_W = 3;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_LOW = 3'h1;
    localparam logic [2:0] PRIO_HIGH = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h4;

    // Interrupt sources, one priority field each
    localparam int unsigned NUM_SRC = 14;
    localparam int unsigned SRC_SERIAL_A_RX = 0;
    localparam int unsigned SRC_SYNC_SERIAL_A_EVENT = 1;
    localparam int unsigned SRC_SYNC_SERIAL_A_FAULT = 2;
    localparam int unsigned SRC_TIMER_C = 3;
    localparam int unsigned SRC_CONVERTER_DONE = 4;
    localparam int unsigned SRC_SERIAL_A_TX = 5;
    localparam int unsigned SRC_PIN_CHANGE = 6;
    localparam int unsigned SRC_COMPARATOR = 7;
    localparam int unsigned SRC_TWOWIRE_A_MASTER = 8;
    localparam int unsigned SRC_TWOWIRE_A_SLAVE = 9;
    localparam int unsigned SRC_EXT_PIN_B = 10;
    localparam int unsigned SRC_TIMER_D = 11;
    localparam int unsigned SRC_OUT_COMPARE_D = 12;
    localparam int unsigned SRC_OUT_COMPARE_C = 13;

    // Register index and lowest bit of each source's field
    localparam logic [2:0] FLD_REG [NUM_SRC] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1,
        3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
    localparam logic [3:0] FLD_LSB [NUM_SRC] = '{4'hc, 4'h8, 4'h4, 4'h0, 4'h4, 4'h0,
        4'hc, 4'h8, 4'h4, 4'h0, 4'h0, 4'hc, 4'h8, 4'h4};

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Bus slave phase
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ_WAIT,
        PH_READ_DATA
    } ipr_phase_e;

endpackage

// File: rtl/ipr_fld_if.sv
`timescale 1ns/1ps
// Links the bus slave to one priority field
interface ipr_fld_if;
    logic wr_en; // Commit pulse for this field
    logic [2:0] wdata; // New field value
    logic req_raw; // Request from the peripheral
    logic [2:0] prio; // Stored priority level
    logic req_out; // Request passed on when enabled

    modport fld (input wr_en, input wdata, input req_raw, output prio, output req_out);
    modport ctl (output wr_en, output wdata, output req_raw, input prio, input req_out);
endinterface

// File: rtl/ipr_field.sv
`timescale 1ns/1ps
// One 3-bit priority field with its request gate
module ipr_field
    import ipr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    ipr_fld_if.fld fld
);

    typedef struct packed {
        logic [2:0] prio; // Stored level
        logic req; // Gated request
    } ipr_fld_s;

    ipr_fld_s st_reg;
    ipr_fld_s st_next;

    // Next state: load on commit, gate request by stored level
    always_comb begin
        st_next = st_reg;
        if (fld.wr_en) begin
            st_next.prio = fld.wdata;
        end
        // Level zero masks the source entirely
        st_next.req = fld.req_raw && (st_reg.prio != PRIO_OFF);
    end

    // State register, mid level after reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg.prio <= PRIO_RESET;
            st_reg.req <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fld.prio = st_reg.prio;
    assign fld.req_out = st_reg.req;

    // Reset leaves level four in the field
    chk_reset_level: assert property (@(posedge mclk_i) $rose(rst_n_i) |->
        (st_reg.prio == 3'h4))
        else $error("priority field did not reset to level four");

    // Written code becomes the level, including the extremes
    chk_write_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        fld.wr_en |=> (st_reg.prio == $past(fld.wdata)))
        else $error("priority field did not take written value");

    // Disabled source never raises its request
    chk_off_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (st_reg.prio == 3'h0) |=> !st_reg.req)
        else $error("request passed while level is zero");

    // Any nonzero level from lowest to highest passes the request
    chk_on_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (fld.req_raw && (st_reg.prio >= 3'h1)) |=> st_reg.req)
        else $error("request blocked at an active level");

endmodule // ipr_field

// File: testbench/tb.sv
`timescale 1ns/1ps
// Register-level bench for the priority block, bus master driven directly
module tb;
    import ipr_pkg::*;

    logic mclk_i; // 20 MHz bench clock
    logic resetn_i; // Active low reset
    logic hsel_i;
    logic [31:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [13:0] req_raw_i; // Raw peripheral requests
    logic [13:0] req_o;
    logic [41:0] prio_o;
    logic [31:0] rd_data; // Read data captured while ready is seen high
    int n_errors = 0;
    int total_checks = 0;

    // Expected layout, one entry per register
    localparam logic [15:0] MASK_TB [5] = '{16'h7777, 16'h0077, 16'h7777, 16'h0007, 16'h7770};
    localparam logic [15:0] RST_TB [5] = '{16'h4444, 16'h0044, 16'h4444, 16'h0004, 16'h4440};
    // Register index and lowest bit of each source field
    localparam int SRC_REG [14] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 2, 3, 4, 4, 4};
    localparam int SRC_LSB [14] = '{12, 8, 4, 0, 4, 0, 12, 8, 4, 0, 0, 12, 8, 4};

    ipr_top uut (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .req_raw_i(req_raw_i),
        .req_o(req_o),
        .prio_o(prio_o)
    );

    // Free running clock
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One comparison of a design value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Ready and read data are taken at the rising edge, before that edge's updates land
    task automatic wait_ready();
        int n = 0;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            print_verdict();
        end
        rd_data = hrdata_o;
    endtask

    // Single word transfer: address phase, then data phase
    task automatic bus_xfer(input logic [31:0] addr, input logic wr, input logic [31:0] data);
        @(posedge mclk_i);
        hsel_i <= 1'b1;
        htrans_i <= HTRANS_NONSEQ;
        haddr_i <= addr;
        hwrite_i <= wr;
        hsize_i <= 3'h2;
        wait_ready();
        htrans_i <= 2'h0;
        hwdata_i <= data;
        wait_ready();
        check({31'h0, hresp_o}, {31'h0, HRESP_OKAY});
    endtask

    // Reset hold and release, long enough for the internal synchroniser
    task automatic apply_reset();
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (20) @(posedge mclk_i);
        // Requests stay blocked for the whole reset, whatever the raw inputs do
        check({18'h0, req_o}, 32'h0);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
    endtask

    // Every register and field at its power-on pattern
    task automatic test_reset_values();
        for (int r = 0; r < 5; r++) begin
            bus_xfer({24'h0, REG_OFF[r]}, 1'b0, 32'h0);
            check(rd_data, {16'h0, RST_TB[r]});
        end
        @(negedge mclk_i);
        for (int s = 0; s < 14; s++) begin
            check({29'h0, prio_o[3*s +: 3]}, {29'h0, 3'h4});
        end
        // Level four is active, so every raw request passes
        check({18'h0, req_o}, {18'h0, req_raw_i});
        $display("test reset_values done");
    endtask

    // Distinct codes per field locate each source's bits
    task automatic test_field_map();
        logic [15:0] wr [5];
        logic [15:0] got;
        wr = '{16'h1357, 16'hff26, 16'h7531, 16'hfff5, 16'h246f};
        for (int r = 0; r < 5; r++) begin
            bus_xfer({24'h0, REG_OFF[r]}, 1'b1, {16'hffff, wr[r]});
        end
        for (int r = 0; r < 5; r++) begin
            bus_xfer({24'h0, REG_OFF[r]}, 1'b0, 32'h0);
            check(rd_data, {16'h0, wr[r] & MASK_TB[r]});
        end
        @(negedge mclk_i);
        for (int s = 0; s < 14; s++) begin
            got = wr[SRC_REG[s]] >> SRC_LSB[s];
            check({29'h0, prio_o[3*s +: 3]}, {29'h0, got[2:0]});
        end
        $display("test field_map done");
    endtask

    // Sweep all level codes, also setting the gap bit above each field position
    task automatic test_level_codes();
        logic [15:0] word;
        logic [13:0] pat;
        for (int c = 0; c < 8; c++) begin
            word = {4{1'b1, c[2:0]}};
            pat = c[0] ? 14'h3fff : 14'h1555;
            @(posedge mclk_i);
            req_raw_i <= pat;
            for (int r = 0; r < 5; r++) begin
                bus_xfer({24'h0, REG_OFF[r]}, 1'b1, {16'h0, word});
            end
            for (int r = 0; r < 5; r++) begin
                bus_xfer({24'h0, REG_OFF[r]}, 1'b0, 32'h0);
                check(rd_data, {16'h0, {4{1'b0, c[2:0]}} & MASK_TB[r]});
            end
            @(negedge mclk_i);
            for (int s = 0; s < 14; s++) begin
                check({29'h0, prio_o[3*s +: 3]}, {29'h0, c[2:0]});
            end
            check({18'h0, req_o}, (c == 0) ? 32'h0 : {18'h0, pat});
        end
        $display("test level_codes done");
    endtask

    // Unmapped offset: write dropped, read zero, neighbours untouched
    task automatic test_unmapped();
        bus_xfer(32'h0000_0000, 1'b1, 32'h0000_7777);
        bus_xfer(32'h0000_0014, 1'b1, 32'hffff_ffff);
        bus_xfer(32'h0000_0014, 1'b0, 32'h0);
        check(rd_data, 32'h0);
        bus_xfer(32'h0000_0000, 1'b0, 32'h0);
        check(rd_data, 32'h0000_7777);
        bus_xfer(32'h0000_0010, 1'b0, 32'h0);
        check(rd_data, 32'h0000_7770);
        $display("test unmapped done");
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        req_raw_i = 14'h0;
        apply_reset();
        test_reset_values();
        test_field_map();
        test_level_codes();
        test_unmapped();
        req_raw_i <= 14'h3fff;
        apply_reset();
        test_reset_values();
        print_verdict();
    end
endmodule // tb
